// *** debug_breakpoint_watch_unit.sv ***
/*
 Debug breakpoint and watch unit of one tile: instruction breakpoints,
 data and resource watchpoints, debug cause capture, thread halt mask
 and shared scratch words, all on one Wishbone classic slave.
 Assumes the pipeline observation inputs are on the tile clock and the
 probe request arrives from another clock domain.
*/
`timescale 1ns/10ps
`include "dbg_watch_cfg.svh"

module debug_breakpoint_watch_unit #(
  parameter int NumWatch = 4,
  parameter int NumScratch = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire dbg_watch_pkg::wb_req_t wbReq,
  output logic [31:0] wbDatRd,
  output logic wbAck,
  input wire dbg_watch_pkg::fetch_obs_t fetchObs,
  input wire dbg_watch_pkg::mem_obs_t memObs,
  input wire dbg_watch_pkg::res_obs_t resObs,
  input wire dbg_watch_pkg::sw_call_t softwareDebugCall,
  input wire logic probeRequest,
  input wire logic debugReturn,
  input wire dbg_watch_pkg::scratch_req_t cfgScratchReq,
  output logic [31:0] cfgScratchRdata,
  output logic debugIrq,
  output logic inDebug,
  output logic [7:0] threadHalt
);
  import dbg_watch_pkg::*;

  // ==========================================================
  // storage
  logic [31:0] ibAddr_q [NumWatch];
  logic [31:0] ibCtrl_q [NumWatch];
  logic [31:0] dwLower_q [NumWatch];
  logic [31:0] dwUpper_q [NumWatch];
  logic [31:0] dwCtrl_q [NumWatch];
  logic [31:0] rwMask_q [NumWatch];
  logic [31:0] rwValue_q [NumWatch];
  logic [31:0] rwCtrl_q [NumWatch];
  logic [31:0] scratch_q [NumScratch];
  logic [31:0] cause_q;
  logic [31:0] eventData_q;
  logic [7:0] haltMask_q;
  logic inDebug_q;
  logic debugIrq_q;
  logic [7:0] threadHalt_q;
  logic wbAck_q;
  logic [31:0] wbDatRd_q;
  logic [31:0] cfgScratchRdata_q;
  logic probeMeta_q;
  logic probeSync_q;

  // ==========================================================
  // bus decode
  logic [7:0] regIdx;
  logic wbWrite;
  logic wbRead;
  logic [31:0] byteMask;

  assign regIdx = wbReq.adr[9:2];
  assign wbWrite = wbReq.cyc & wbReq.stb & wbReq.we & ~wbAck_q;
  assign wbRead = wbReq.cyc & wbReq.stb & ~wbReq.we & ~wbAck_q;
  assign byteMask = {{8{wbReq.sel[3]}}, {8{wbReq.sel[2]}}, {8{wbReq.sel[1]}},
    {8{wbReq.sel[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
    input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  function automatic logic hitsReg(input logic [7:0] idx, input logic [7:0] base,
    input int n);
    hitsReg = (idx >= base) && ({24'h0, idx} < {24'h0, base} + 32'(n));
  endfunction : hitsReg

  function automatic logic [1:0] lowestHit(input logic [NumWatch-1:0] hits);
    lowestHit = 2'h0;
    for (int i = NumWatch - 1; i >= 0; i--) begin
      if (hits[i]) begin
        lowestHit = 2'(i);
      end
    end
  endfunction : lowestHit

  // ==========================================================
  // probe request synchroniser
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      probeMeta_q <= 1'b0;
      probeSync_q <= 1'b0;
    end else begin
      probeMeta_q <= probeRequest;
      probeSync_q <= probeMeta_q;
    end
  end

  // ==========================================================
  // hit detection
  logic [NumWatch-1:0] ibHit;
  logic [NumWatch-1:0] dwHit;
  logic [NumWatch-1:0] rwHit;

  always_comb begin
    for (int i = 0; i < NumWatch; i++) begin
      logic condA;
      logic condB;
      condA = memObs.addr >= dwLower_q[i];
      condB = memObs.addr <= dwUpper_q[i];
      ibHit[i] = fetchObs.valid & ibCtrl_q[i][`WATCH_ENABLE_BIT]
        & ibCtrl_q[i][`THREAD_EN_LSB + 32'(fetchObs.thread)]
        & ((fetchObs.pc == ibAddr_q[i]) ^ ibCtrl_q[i][`IBP_INVERT_BIT]);
      dwHit[i] = memObs.valid & dwCtrl_q[i][`WATCH_ENABLE_BIT]
        & dwCtrl_q[i][`THREAD_EN_LSB + 32'(memObs.thread)]
        & (memObs.isStore | dwCtrl_q[i][`WATCH_LOADS_BIT])
        & (dwCtrl_q[i][`RANGE_COMBINE_BIT] ? (condA | condB) : (condA & condB));
      rwHit[i] = resObs.valid & rwCtrl_q[i][`WATCH_ENABLE_BIT]
        & rwCtrl_q[i][`THREAD_EN_LSB + 32'(resObs.thread)]
        & ((resObs.resId & rwMask_q[i]) == (rwValue_q[i] & rwMask_q[i]));
    end
  end

  // ==========================================================
  // entry decision, probe first then call then hits in order
  logic enterDebug;
  debug_cause_code_t entryCause;
  logic [1:0] entryIndex;
  logic [7:0] entryThread;
  logic entryLoadsData;
  logic [31:0] entryData;

  always_comb begin
    entryCause = CauseNone;
    entryIndex = 2'h0;
    entryThread = 8'h00;
    entryLoadsData = 1'b0;
    entryData = eventData_q;
    if (probeSync_q) begin
      entryCause = CauseProbe;
    end else if (softwareDebugCall.valid) begin
      entryCause = CauseSwCall;
      entryThread = {5'h00, softwareDebugCall.thread};
    end else if (|ibHit) begin
      entryCause = CauseInstrBp;
      entryIndex = lowestHit(ibHit);
      entryThread = {5'h00, fetchObs.thread};
    end else if (|dwHit) begin
      entryCause = CauseDataWp;
      entryIndex = lowestHit(dwHit);
      entryThread = {5'h00, memObs.thread};
      entryLoadsData = 1'b1;
      entryData = memObs.addr;
    end else if (|rwHit) begin
      entryCause = CauseResWp;
      entryIndex = lowestHit(rwHit);
      entryThread = {5'h00, resObs.thread};
      entryLoadsData = 1'b1;
      entryData = resObs.resId;
    end
  end

  assign enterDebug = ~inDebug_q & (entryCause != CauseNone);

  // ==========================================================
  // debug mode, interrupt and halt outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      inDebug_q <= 1'b0;
      debugIrq_q <= 1'b0;
      threadHalt_q <= 8'h00;
    end else begin
      debugIrq_q <= enterDebug;
      if (enterDebug) begin
        inDebug_q <= 1'b1;
      end else if (debugReturn) begin
        inDebug_q <= 1'b0;
      end
      threadHalt_q <= (enterDebug | (inDebug_q & ~debugReturn)) ? 8'h00 : haltMask_q;
    end
  end

  // ==========================================================
  // cause and event data, hardware capture wins over a bus write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cause_q <= `WORD_RESET;
      eventData_q <= `WORD_RESET;
    end else if (enterDebug) begin
      cause_q <= {14'h0, entryIndex, entryThread, 5'h00, entryCause};
      if (entryLoadsData) begin
        eventData_q <= entryData;
      end
    end else if (wbWrite) begin
      if (regIdx == `REG_DEBUG_CAUSE) begin
        cause_q <= merge(cause_q, wbReq.dat, byteMask) & 32'h0003_FF07;
      end
      if (regIdx == `REG_DEBUG_EVENT_DATA) begin
        eventData_q <= merge(eventData_q, wbReq.dat, byteMask);
      end
    end
  end

  // ==========================================================
  // halt mask
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      haltMask_q <= 8'h00;
    end else if (wbWrite && regIdx == `REG_THREAD_HALT_MASK && wbReq.sel[0]) begin
      haltMask_q <= wbReq.dat[7:0];
    end
  end

  // ==========================================================
  // watch registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < NumWatch; i++) begin
        ibAddr_q[i] <= `WORD_RESET;
        ibCtrl_q[i] <= `CTRL_RESET;
        dwLower_q[i] <= `WORD_RESET;
        dwUpper_q[i] <= `WORD_RESET;
        dwCtrl_q[i] <= `CTRL_RESET;
        rwMask_q[i] <= `WORD_RESET;
        rwValue_q[i] <= `WORD_RESET;
        rwCtrl_q[i] <= `CTRL_RESET;
      end
    end else if (wbWrite) begin
      for (int i = 0; i < NumWatch; i++) begin
        if (regIdx == `REG_IBP_ADDRESS_BASE + 8'(i)) begin
          ibAddr_q[i] <= merge(ibAddr_q[i], wbReq.dat, byteMask);
        end
        if (regIdx == `REG_IBP_CONTROL_BASE + 8'(i)) begin
          ibCtrl_q[i] <= merge(ibCtrl_q[i], wbReq.dat, byteMask) & 32'h00FF_0003;
        end
        if (regIdx == `REG_DWP_LOWER_BASE + 8'(i)) begin
          dwLower_q[i] <= merge(dwLower_q[i], wbReq.dat, byteMask);
        end
        if (regIdx == `REG_DWP_UPPER_BASE + 8'(i)) begin
          dwUpper_q[i] <= merge(dwUpper_q[i], wbReq.dat, byteMask);
        end
        if (regIdx == `REG_DWP_CONTROL_BASE + 8'(i)) begin
          dwCtrl_q[i] <= merge(dwCtrl_q[i], wbReq.dat, byteMask) & 32'h00FF_0007;
        end
        if (regIdx == `REG_RWP_MASK_BASE + 8'(i)) begin
          rwMask_q[i] <= merge(rwMask_q[i], wbReq.dat, byteMask);
        end
        if (regIdx == `REG_RWP_VALUE_BASE + 8'(i)) begin
          rwValue_q[i] <= merge(rwValue_q[i], wbReq.dat, byteMask);
        end
        if (regIdx == `REG_RWP_CONTROL_BASE + 8'(i)) begin
          rwCtrl_q[i] <= merge(rwCtrl_q[i], wbReq.dat, byteMask) & 32'h00FF_0001;
        end
      end
    end
  end

  // ==========================================================
  // shared scratch words, bus write wins over the configuration port
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < NumScratch; i++) begin
        scratch_q[i] <= `WORD_RESET;
      end
      cfgScratchRdata_q <= `WORD_RESET;
    end else begin
      cfgScratchRdata_q <= scratch_q[cfgScratchReq.index];
      for (int i = 0; i < NumScratch; i++) begin
        if (wbWrite && regIdx == `REG_SCRATCH_BASE + 8'(i)) begin
          scratch_q[i] <= merge(scratch_q[i], wbReq.dat, byteMask);
        end else if (cfgScratchReq.we && cfgScratchReq.index == 3'(i)) begin
          scratch_q[i] <= cfgScratchReq.dat;
        end
      end
    end
  end

  // ==========================================================
  // read mux, unmapped words read zero
  logic [31:0] readWord;

  always_comb begin
    readWord = 32'h0000_0000;
    if (regIdx == `REG_DEBUG_CAUSE) begin
      readWord = cause_q;
    end
    if (regIdx == `REG_DEBUG_EVENT_DATA) begin
      readWord = eventData_q;
    end
    if (regIdx == `REG_THREAD_HALT_MASK) begin
      readWord = {24'h0, haltMask_q};
    end
    if (regIdx == `REG_DEBUG_STATUS) begin
      readWord = {31'h0, inDebug_q};
    end
    for (int i = 0; i < NumScratch; i++) begin
      if (regIdx == `REG_SCRATCH_BASE + 8'(i)) begin
        readWord = scratch_q[i];
      end
    end
    for (int i = 0; i < NumWatch; i++) begin
      if (regIdx == `REG_IBP_ADDRESS_BASE + 8'(i)) begin
        readWord = ibAddr_q[i];
      end
      if (regIdx == `REG_IBP_CONTROL_BASE + 8'(i)) begin
        readWord = ibCtrl_q[i];
      end
      if (regIdx == `REG_DWP_LOWER_BASE + 8'(i)) begin
        readWord = dwLower_q[i];
      end
      if (regIdx == `REG_DWP_UPPER_BASE + 8'(i)) begin
        readWord = dwUpper_q[i];
      end
      if (regIdx == `REG_DWP_CONTROL_BASE + 8'(i)) begin
        readWord = dwCtrl_q[i];
      end
      if (regIdx == `REG_RWP_MASK_BASE + 8'(i)) begin
        readWord = rwMask_q[i];
      end
      if (regIdx == `REG_RWP_VALUE_BASE + 8'(i)) begin
        readWord = rwValue_q[i];
      end
      if (regIdx == `REG_RWP_CONTROL_BASE + 8'(i)) begin
        readWord = rwCtrl_q[i];
      end
    end
  end

  // ==========================================================
  // wishbone answer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wbAck_q <= 1'b0;
      wbDatRd_q <= 32'h0000_0000;
    end else begin
      wbAck_q <= wbReq.cyc & wbReq.stb & ~wbAck_q;
      if (wbRead) begin
        wbDatRd_q <= readWord;
      end
    end
  end

  assign wbAck = wbAck_q;
  assign wbDatRd = wbDatRd_q;
  assign cfgScratchRdata = cfgScratchRdata_q;
  assign debugIrq = debugIrq_q;
  assign inDebug = inDebug_q;
  assign threadHalt = threadHalt_q;

endmodule : debug_breakpoint_watch_unit

// *** dbg_watch_cfg.svh ***
/*
 Offsets, field positions, reset values and cause codes of the debug
 breakpoint and watch unit. Assumes register indices are word indices
 on a 32-bit bus, so the byte address is four times the index.
*/
`ifndef DBG_WATCH_CFG_SVH
`define DBG_WATCH_CFG_SVH

// ==========================================================
// register indices
`define REG_DEBUG_CAUSE 8'h15
`define REG_DEBUG_EVENT_DATA 8'h16
`define REG_THREAD_HALT_MASK 8'h18
`define REG_SCRATCH_BASE 8'h20
`define REG_IBP_ADDRESS_BASE 8'h30
`define REG_IBP_CONTROL_BASE 8'h40
`define REG_DWP_LOWER_BASE 8'h50
`define REG_DWP_UPPER_BASE 8'h60
`define REG_DWP_CONTROL_BASE 8'h70
`define REG_RWP_MASK_BASE 8'h80
`define REG_RWP_VALUE_BASE 8'h90
`define REG_RWP_CONTROL_BASE 8'hA0
`define REG_DEBUG_STATUS 8'hA8

// ==========================================================
// field positions
`define WATCH_ENABLE_BIT 0
`define RANGE_COMBINE_BIT 1
`define IBP_INVERT_BIT 1
`define WATCH_LOADS_BIT 2
`define THREAD_EN_LSB 16
`define CAUSE_CODE_LSB 0
`define CAUSE_INDEX_LSB 16
`define CAUSE_THREAD_LSB 8

// ==========================================================
// cause codes
`define CAUSE_NONE 3'h0
`define CAUSE_PROBE 3'h1
`define CAUSE_SW_CALL 3'h2
`define CAUSE_INSTR_BP 3'h3
`define CAUSE_DATA_WP 3'h4
`define CAUSE_RES_WP 3'h5

// ==========================================================
// reset values
`define CTRL_RESET 32'h0000_0000
`define WORD_RESET 32'h0000_0000

`endif

// *** dbg_watch_pkg.sv ***
/*
 Types of the debug breakpoint and watch unit.
 Assumes dbg_watch_cfg.svh is on the include path.
*/
`include "dbg_watch_cfg.svh"

package dbg_watch_pkg;

  // ==========================================================
  // cause codes
  typedef enum logic [2:0] {
    CauseNone = `CAUSE_NONE,
    CauseProbe = `CAUSE_PROBE,
    CauseSwCall = `CAUSE_SW_CALL,
    CauseInstrBp = `CAUSE_INSTR_BP,
    CauseDataWp = `CAUSE_DATA_WP,
    CauseResWp = `CAUSE_RES_WP
  } debug_cause_code_t;

  // ==========================================================
  // pipeline observation, bus request and scratch port carriers
  typedef struct packed {
    logic valid;
    logic [2:0] thread;
    logic [31:0] pc;
  } fetch_obs_t;

  typedef struct packed {
    logic valid;
    logic isStore;
    logic [2:0] thread;
    logic [31:0] addr;
  } mem_obs_t;

  typedef struct packed {
    logic valid;
    logic [2:0] thread;
    logic [31:0] resId;
  } res_obs_t;

  typedef struct packed {
    logic valid;
    logic [2:0] thread;
  } sw_call_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic we;
    logic [2:0] index;
    logic [31:0] dat;
  } scratch_req_t;

endpackage : dbg_watch_pkg

// *** debug_breakpoint_watch_unit_props.sv ***
/*
 Port checker of the debug breakpoint and watch unit.
 Assumes one tile clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module debug_breakpoint_watch_unit_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire dbg_watch_pkg::wb_req_t wbReq,
  input wire logic wbAck,
  input wire dbg_watch_pkg::sw_call_t softwareDebugCall,
  input wire logic debugReturn,
  input wire logic debugIrq,
  input wire logic inDebug,
  input wire logic [7:0] threadHalt
);
  import dbg_watch_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // bus handshake
  a_ack_single: assert property (wbAck |=> !wbAck)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wbReq.cyc && wbReq.stb && !wbAck |=> wbAck)
    else $error("request not acked in one cycle");
  a_ack_cause: assert property ($rose(wbAck) |-> $past(wbReq.cyc && wbReq.stb))
    else $error("ack without request");
  // ==========================================================
  // debug entry and exit
  a_irq_entry: assert property (debugIrq |-> inDebug && !$past(inDebug))
    else $error("irq without fresh debug entry");
  a_irq_pulse: assert property (debugIrq |=> !debugIrq)
    else $error("irq longer than one cycle");
  a_call_entry: assert property (softwareDebugCall.valid && !inDebug |=> inDebug && debugIrq)
    else $error("software call did not enter debug");
  a_halt_debug: assert property (inDebug |-> threadHalt == 8'h00)
    else $error("threads halted while in debug");
  a_return_exit: assert property (inDebug && debugReturn |=> !inDebug)
    else $error("debug return ignored");
endmodule : debug_breakpoint_watch_unit_props

bind debug_breakpoint_watch_unit debug_breakpoint_watch_unit_props
  i_debug_breakpoint_watch_unit_props (.clock(clock), .rst_n(rst_n), .wbReq(wbReq),
  .wbAck(wbAck), .softwareDebugCall(softwareDebugCall), .debugReturn(debugReturn),
  .debugIrq(debugIrq), .inDebug(inDebug), .threadHalt(threadHalt));

// *** pipeline_model.sv ***
/*
 Core pipeline model: issues one observation per call, then idles.
 Assumes callers sit just after a rising clock edge.
*/
`timescale 1ns/10ps
module pipeline_model (
  input wire logic clock,
  output dbg_watch_pkg::fetch_obs_t fetchObs,
  output dbg_watch_pkg::mem_obs_t memObs,
  output dbg_watch_pkg::res_obs_t resObs,
  output dbg_watch_pkg::sw_call_t softwareDebugCall,
  output logic debugReturn
);
  import dbg_watch_pkg::*;
  initial begin
    fetchObs = '0;
    memObs = '0;
    resObs = '0;
    softwareDebugCall = '0;
    debugReturn = 1'b0;
  end
  // ==========================================================
  // one-cycle issue; idle fields show junk, not the last value
  task automatic issuePc(input logic [2:0] t, input logic [31:0] pc);
    @(posedge clock);
    fetchObs <= '{valid: 1'b1, thread: t, pc: pc};
    @(posedge clock);
    fetchObs <= '{valid: 1'b0, thread: ~t, pc: ~pc};
  endtask : issuePc
  task automatic issueMem(input logic st, input logic [2:0] t, input logic [31:0] a);
    @(posedge clock);
    memObs <= '{valid: 1'b1, isStore: st, thread: t, addr: a};
    @(posedge clock);
    memObs <= '{valid: 1'b0, isStore: ~st, thread: ~t, addr: ~a};
  endtask : issueMem
  task automatic issueRes(input logic [2:0] t, input logic [31:0] id);
    @(posedge clock);
    resObs <= '{valid: 1'b1, thread: t, resId: id};
    @(posedge clock);
    resObs <= '{valid: 1'b0, thread: ~t, resId: ~id};
  endtask : issueRes
  task automatic issueCall(input logic [2:0] t);
    @(posedge clock);
    softwareDebugCall <= '{valid: 1'b1, thread: t};
    @(posedge clock);
    softwareDebugCall <= '{valid: 1'b0, thread: ~t};
  endtask : issueCall
  task automatic retire();
    @(posedge clock);
    debugReturn <= 1'b1;
    @(posedge clock);
    debugReturn <= 1'b0;
  endtask : retire
endmodule : pipeline_model

// *** debug_breakpoint_watch_unit_tb_top.sv ***
/*
 Self-checking bench of the debug breakpoint and watch unit.
 Assumes pipeline_model and the bound port checker are compiled before.
*/
`timescale 1ns/10ps
`include "dbg_watch_cfg.svh"
module debug_breakpoint_watch_unit_tb_top;
  import dbg_watch_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic probeRequest = 1'b0;
  wb_req_t wbReq = '0;
  scratch_req_t cfgScratchReq = '0;
  fetch_obs_t fetchObs;
  mem_obs_t memObs;
  res_obs_t resObs;
  sw_call_t softwareDebugCall;
  logic debugReturn, wbAck, debugIrq, inDebug;
  logic [31:0] wbDatRd, cfgScratchRdata;
  logic [7:0] threadHalt;
  int n_fail = 0;
  int num_checks = 0;
  always #12.5 clock = ~clock;
  debug_breakpoint_watch_unit i_debug_breakpoint_watch_unit (.clock(clock), .rst_n(rst_n),
    .wbReq(wbReq), .wbDatRd(wbDatRd), .wbAck(wbAck), .fetchObs(fetchObs), .memObs(memObs),
    .resObs(resObs), .softwareDebugCall(softwareDebugCall), .probeRequest(probeRequest),
    .debugReturn(debugReturn), .cfgScratchReq(cfgScratchReq),
    .cfgScratchRdata(cfgScratchRdata), .debugIrq(debugIrq), .inDebug(inDebug),
    .threadHalt(threadHalt));
  pipeline_model i_pipeline_model (.clock(clock), .fetchObs(fetchObs), .memObs(memObs),
    .resObs(resObs), .softwareDebugCall(softwareDebugCall), .debugReturn(debugReturn));
  // ==========================================================
  // shared helpers
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check32
  task automatic wbXfer(input logic we, input logic [7:0] idx, input logic [31:0] d,
                        output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'hF, dat: d};
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    q = wbDatRd;
    wbReq <= '0;
    check32({31'h0, wbAck}, 32'h1);
  endtask : wbXfer
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    wbXfer(1'b1, idx, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    wbXfer(1'b0, idx, 32'h0, q);
    check32(q, exp);
  endtask : rd
  function automatic logic [31:0] causeWord(input logic [2:0] c, input logic [2:0] t,
                                            input logic [1:0] i);
    return {14'h0, i, 5'h0, t, 5'h0, c};
  endfunction : causeWord
  task automatic expectEntry(input logic [31:0] cause, input logic [31:0] data, input bit chk);
    #1;
    check32({31'h0, inDebug}, 32'h1);
    rd(`REG_DEBUG_CAUSE, cause);
    if (chk) rd(`REG_DEBUG_EVENT_DATA, data);
    rd(`REG_DEBUG_STATUS, 32'h1);
    i_pipeline_model.retire();
    #1;
    check32({31'h0, inDebug}, 32'h0);
  endtask : expectEntry
  task automatic noEntry();
    #1;
    check32({31'h0, inDebug}, 32'h0);
    check32({31'h0, debugIrq}, 32'h0);
  endtask : noEntry
  // ==========================================================
  // scenarios
  task automatic test_reset();
    for (int i = 0; i < 4; i++) begin
      rd(`REG_IBP_CONTROL_BASE + i[7:0], 32'h0);
      rd(`REG_DWP_CONTROL_BASE + i[7:0], 32'h0);
    end
    rd(`REG_DEBUG_CAUSE, 32'h0);
  endtask : test_reset
  task automatic test_regs();
    wr(`REG_SCRATCH_BASE + 8'h3, 32'hA5A5_0F0F);
    @(posedge clock);
    cfgScratchReq <= '{we: 1'b0, index: 3'h3, dat: 32'h0};
    @(posedge clock);
    cfgScratchReq <= '{we: 1'b1, index: 3'h7, dat: 32'h1357_9BDF};
    #1;
    check32(cfgScratchRdata, 32'hA5A5_0F0F);
    @(posedge clock);
    cfgScratchReq <= '0;
    rd(`REG_SCRATCH_BASE + 8'h7, 32'h1357_9BDF);
    rd(8'h1F, 32'h0);
    wr(`REG_RWP_MASK_BASE + 8'h3, 32'hDEAD_BEEF);
    rd(`REG_RWP_MASK_BASE + 8'h3, 32'hDEAD_BEEF);
    wr(`REG_RWP_VALUE_BASE + 8'h3, 32'hC0DE_F00D);
    rd(`REG_RWP_VALUE_BASE + 8'h3, 32'hC0DE_F00D);
    wr(`REG_THREAD_HALT_MASK, 32'h0000_0105);
    rd(`REG_THREAD_HALT_MASK, 32'h0000_0005);
    check32({24'h0, threadHalt}, 32'h5);
  endtask : test_regs
  task automatic test_ibp();
    for (int i = 0; i < 3; i++) wr(`REG_IBP_ADDRESS_BASE + i[7:0], 32'h0000_0100);
    wr(`REG_IBP_CONTROL_BASE, 32'h0001_0001);
    wr(`REG_IBP_CONTROL_BASE + 8'h1, 32'h0004_0001);
    wr(`REG_IBP_CONTROL_BASE + 8'h2, 32'h0004_0001);
    i_pipeline_model.issuePc(3'h2, 32'h0000_0100);
    expectEntry(causeWord(3'h3, 3'h2, 2'h1), 32'h0, 1'b0);
    wr(`REG_IBP_CONTROL_BASE, 32'h0);
    wr(`REG_IBP_CONTROL_BASE + 8'h1, 32'h0);
    wr(`REG_IBP_CONTROL_BASE + 8'h2, 32'h0004_0003);
    i_pipeline_model.issuePc(3'h2, 32'h0000_0100);
    noEntry();
    i_pipeline_model.issuePc(3'h2, 32'h0000_0104);
    expectEntry(causeWord(3'h3, 3'h2, 2'h2), 32'h0, 1'b0);
    wr(`REG_IBP_CONTROL_BASE + 8'h2, 32'h0);
  endtask : test_ibp
  task automatic test_dwp();
    wr(`REG_DWP_LOWER_BASE + 8'h1, 32'h0000_1000);
    wr(`REG_DWP_UPPER_BASE + 8'h1, 32'h0000_1FFC);
    wr(`REG_DWP_CONTROL_BASE + 8'h1, 32'h0008_0001);
    i_pipeline_model.issueMem(1'b0, 3'h3, 32'h0000_1800);
    noEntry();
    i_pipeline_model.issueMem(1'b1, 3'h3, 32'h0000_2000);
    noEntry();
    i_pipeline_model.issueMem(1'b1, 3'h2, 32'h0000_1800);
    noEntry();
    i_pipeline_model.issueMem(1'b1, 3'h3, 32'h0000_1FFC);
    expectEntry(causeWord(3'h4, 3'h3, 2'h1), 32'h0000_1FFC, 1'b1);
    wr(`REG_DWP_CONTROL_BASE + 8'h1, 32'h0008_0007);
    i_pipeline_model.issueMem(1'b0, 3'h3, 32'h0000_0800);
    expectEntry(causeWord(3'h4, 3'h3, 2'h1), 32'h0000_0800, 1'b1);
    wr(`REG_DWP_CONTROL_BASE + 8'h1, 32'h0);
  endtask : test_dwp
  task automatic test_res();
    wr(`REG_RWP_MASK_BASE, 32'hFFFF_00FF);
    wr(`REG_RWP_VALUE_BASE, 32'h1234_0056);
    wr(`REG_RWP_CONTROL_BASE, 32'h0002_0001);
    i_pipeline_model.issueRes(3'h1, 32'h1234_AB57);
    noEntry();
    i_pipeline_model.issueRes(3'h1, 32'h1234_AB56);
    expectEntry(causeWord(3'h5, 3'h1, 2'h0), 32'h1234_AB56, 1'b1);
    wr(`REG_RWP_CONTROL_BASE, 32'h0);
  endtask : test_res
  task automatic test_call_probe();
    int n;
    i_pipeline_model.issueCall(3'h6);
    expectEntry(causeWord(3'h2, 3'h6, 2'h0), 32'h0, 1'b0);
    @(posedge clock);
    probeRequest <= 1'b1;
    n = 0;
    while (inDebug !== 1'b1 && n < 10) begin
      @(posedge clock);
      #1;
      n++;
    end
    check32({31'h0, debugIrq}, 32'h1);
    @(posedge clock);
    probeRequest <= 1'b0;
    repeat (4) @(posedge clock);
    check32({24'h0, threadHalt}, 32'h0);
    expectEntry(causeWord(3'h1, 3'h0, 2'h0), 32'h0, 1'b0);
    repeat (2) @(posedge clock);
    #1;
    check32({24'h0, threadHalt}, 32'h5);
  endtask : test_call_probe
  // ==========================================================
  // verdict, watchdog and main sequence
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    test_reset();
    test_regs();
    test_ibp();
    test_dwp();
    test_res();
    test_call_probe();
    print_verdict();
  end
endmodule : debug_breakpoint_watch_unit_tb_top
